// *** tb/pasr_bridge_model.sv ***
// Bridge switch driver model seen from the output pins
`timescale 1ns/100ps
`default_nettype none
module pasr_bridge_model (
  // Pins from the block
  input  wire pasr_pkg::pasr_quad_type pin_out_i,
  input  wire pasr_pkg::pasr_quad_type pin_oe_i,
  // Gate drive seen by the switches
  output pasr_pkg::pasr_quad_type      gate_o
);
  import pasr_pkg::*;
  // Pull-downs keep each switch off while its pin is released
  assign gate_o = pin_out_i & pin_oe_i;
endmodule
`default_nettype wire

// *** tb/pasr_tb_top.sv ***
// Self-checking bench for the PWM auto-shutdown block
`timescale 1ns/100ps
`default_nettype none
module pasr_tb_top;
  import pasr_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          resetn_i  = 1'b0;
  logic          psel      = 1'b0;
  logic          penable   = 1'b0;
  logic          pwrite    = 1'b0;
  logic [11:0]   paddr     = 12'h000;
  logic [31:0]   pwdata    = 32'h0;
  logic [3:0]    pstrb     = 4'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          shut;
  logic          pflag;
  logic          pstart    = 1'b0;
  logic [3:0]    pcnt      = 4'h0;
  pasr_quad_type pwm       = 4'h0;
  pasr_quad_type pout;
  pasr_quad_type poe;
  pasr_quad_type gate;
  pasr_src_type  src       = 3'h0;
  logic [31:0]   rd;
  logic          rerr;
  logic          seen_ps;
  int            mismatches = 0;
  int            checks_done = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  // Period pulse every 16 cycles once out of reset
  always @(posedge clk_sys_i) begin
    pcnt <= resetn_i ? pcnt + 4'h1 : 4'h0;
    pstart <= resetn_i && (pcnt == 4'hE);
  end

  pasr_top dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .pwm_i(pwm), .period_start_i(pstart), .src_i(src),
    .pin_out_o(pout), .pin_oe_o(poe),
    .shutdown_o(shut), .period_flag_o(pflag)
  );

  pasr_bridge_model bridge (
    .pin_out_i(pout),
    .pin_oe_i(poe),
    .gate_o(gate)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Outputs are read in the active region, so they hold pre-edge values
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= {24'h0, d};
    pstrb <= 4'h1;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_i);
      if (pready === 1'b1)
        break;
    end
    if (n == 20) begin
      mismatches++;
      print_verdict();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string m);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e}, m);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wait_ps();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (pstart === 1'b1)
        break;
    end
    chk(32'(n < 40), 32'h1, "period start wait");
    if (n == 40)
      print_verdict();
  endtask

  task automatic wait_shut(input logic want);
    int n;
    seen_ps = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (shut === want)
        break;
      if (pstart === 1'b1)
        seen_ps = 1'b1;
    end
    chk(32'(n < 40), 32'h1, "shutdown level wait");
    if (n == 40)
      print_verdict();
  endtask

  initial begin
    tick(4);
    resetn_i <= 1'b1;
    tick(1);
    chk(poe, 4'h0, "pins released after reset");
    wait_ps();
    tick(2);
    chk(pflag, 1'b0, "flag after first period");
    wait_ps();
    tick(2);
    chk(pflag, 1'b1, "flag after second period");
    rdchk(PASR_PST_OFF, 8'h01, "status flag");
    rdchk(PASR_ASC_OFF, 8'h00, "control reset");
    rdchk(PASR_DBC_OFF, 8'h00, "config reset");
    apb(1'b0, 8'h14, 8'h00);
    chk(rerr, 1'b1, "unmapped refused");
    $display("test reset done");

    // Polarity first, pins only after a full cycle
    apb(1'b1, PASR_PWC_OFF, 8'h01);
    pwm <= 4'h3;
    apb(1'b1, PASR_PEN_OFF, 8'h0F);
    tick(2);
    chk(poe, 4'hF, "pins driven");
    chk(gate, 4'h6, "normal polarity");
    $display("test startup done");

    // Trip pin, no restart: A/C high, B/D released
    apb(1'b1, PASR_ASC_OFF, 8'h46);
    src <= 3'h4;
    tick(2);
    chk(shut, 1'b1, "trip shutdown");
    chk(poe, 4'h5, "B/D released");
    chk(gate, 4'h5, "A/C high");
    rdchk(PASR_ASC_OFF, 8'hC6, "flag set by trip");
    apb(1'b1, PASR_ASC_OFF, 8'h46);
    rdchk(PASR_ASC_OFF, 8'hC6, "clear ignored");
    src <= 3'h0;
    tick(3);
    rdchk(PASR_ASC_OFF, 8'hC6, "flag held");
    apb(1'b1, PASR_ASC_OFF, 8'h46);
    rdchk(PASR_ASC_OFF, 8'h46, "firmware clear");
    wait_shut(1'b0);
    chk(seen_ps, 1'b1, "resume at period start");
    tick(1);
    chk(gate, 4'h6, "normal after resume");
    $display("test trip done");

    // Comparator 1 with restart: both pairs low
    apb(1'b1, PASR_DBC_OFF, 8'h80);
    apb(1'b1, PASR_ASC_OFF, 8'h50);
    src <= 3'h2;
    tick(3);
    rdchk(PASR_ASC_OFF, 8'h50, "unselected source");
    src <= 3'h1;
    tick(2);
    chk(shut, 1'b1, "comparator shutdown");
    chk({poe, gate}, 8'hF0, "pairs low");
    apb(1'b1, PASR_ASC_OFF, 8'h50);
    rdchk(PASR_ASC_OFF, 8'hD0, "comparator level");
    src <= 3'h0;
    // Watch from the release on, a period start may come at once
    wait_shut(1'b0);
    chk(seen_ps, 1'b1, "auto resume at period");
    rdchk(PASR_ASC_OFF, 8'h50, "auto clear");
    $display("test restart done");

    // No source selected; software force, B/D high
    apb(1'b1, PASR_DBC_OFF, 8'h00);
    apb(1'b1, PASR_ASC_OFF, 8'h00);
    src <= 3'h7;
    tick(3);
    rdchk(PASR_ASC_OFF, 8'h00, "sources disabled");
    src <= 3'h0;
    apb(1'b1, PASR_ASC_OFF, 8'h81);
    tick(2);
    chk(shut, 1'b1, "forced shutdown");
    chk(gate, 4'hA, "B/D high");
    rdchk(PASR_ASC_OFF, 8'h81, "forced flag");
    apb(1'b1, PASR_ASC_OFF, 8'h00);
    wait_shut(1'b0);
    chk(gate, 4'h6, "normal after force");
    $display("test force done");
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/pasr_pair_stage.sv ***
// Output stage for one pin pair: polarity, shutdown level, drive enable
`timescale 1ns/100ps
`default_nettype none
module pasr_pair_stage (
  // Modulated inputs and pin enables of the pair
  input  wire logic [1:0]             pwm_i,
  input  wire logic [1:0]             en_i,
  // Configuration
  input  wire logic                   pol_low_i,
  input  wire pasr_pkg::pasr_pss_type state_i,
  input  wire logic                   shut_i,
  // Pin levels
  output logic [1:0]                  out_o,
  output logic [1:0]                  oe_o
);
  import pasr_pkg::*;

  always_comb begin
    out_o = pwm_i ^ {2{pol_low_i}};
    oe_o  = en_i;
    if (shut_i) begin
      case (state_i)
        PASR_PSS_LOW:  out_o = 2'h0;
        PASR_PSS_HIGH: out_o = 2'h3;
        default: begin
          out_o = 2'h0;
          oe_o  = 2'h0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** verilog/pasr_pkg.sv ***
// Constants, field layout and carrier types of the PWM auto-shutdown block
package pasr_pkg;

  // Register byte offsets
  localparam logic [7:0] PASR_ASC_OFF = 8'h00;
  localparam logic [7:0] PASR_DBC_OFF = 8'h04;
  localparam logic [7:0] PASR_PWC_OFF = 8'h08;
  localparam logic [7:0] PASR_PEN_OFF = 8'h0C;
  localparam logic [7:0] PASR_PST_OFF = 8'h10;

  // Auto-shutdown control fields
  localparam int PASR_FLAG_BIT = 7;
  localparam int PASR_SRC_HI   = 6;
  localparam int PASR_SRC_LO   = 4;
  localparam int PASR_AC_HI    = 3;
  localparam int PASR_AC_LO    = 2;
  localparam int PASR_BD_HI    = 1;
  localparam int PASR_BD_LO    = 0;

  // Dead-band configuration fields
  localparam int PASR_RST_EN_BIT = 7;
  localparam int PASR_DLY_HI     = 6;
  localparam int PASR_DLY_LO     = 0;

  // Polarity bits, pin enables, status
  localparam int PASR_POL_AC_BIT = 0;
  localparam int PASR_POL_BD_BIT = 1;
  localparam int PASR_PEN_HI     = 3;
  localparam int PASR_PTF_BIT    = 0;

  // Reset values
  localparam logic [7:0] PASR_ASC_RST = 8'h00;
  localparam logic [7:0] PASR_DBC_RST = 8'h00;
  localparam logic [1:0] PASR_POL_RST = 2'h0;
  localparam logic [3:0] PASR_PEN_RST = 4'h0;

  // Source select codes
  localparam logic [2:0] PASR_SRC_NONE = 3'h0;
  localparam logic [2:0] PASR_SRC_TRIP = 3'h4;

  // Pair shutdown state encoding
  typedef enum logic [1:0] {
    PASR_PSS_LOW  = 2'b00,
    PASR_PSS_HIGH = 2'b01,
    PASR_PSS_TRI0 = 2'b10,
    PASR_PSS_TRI1 = 2'b11
  } pasr_pss_type;

  // Shutdown sources
  typedef struct packed {
    logic trip;
    logic cmp2;
    logic cmp1;
  } pasr_src_type;

  // One bit per output pin
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } pasr_quad_type;

endpackage

// *** verilog/pasr_src_decode.sv ***
// Shutdown source selection and combining
`timescale 1ns/100ps
`default_nettype none
module pasr_src_decode (
  // Selection
  input  wire logic [2:0]            sel_i,
  // Raw sources
  input  wire pasr_pkg::pasr_src_type src_i,
  // Result
  output logic                       active_o
);
  import pasr_pkg::*;

  // Code bit 0 picks comparator 1, bit 1 comparator 2, bit 2 trip pin
  always_comb begin
    active_o = (sel_i[0] & src_i.cmp1) | (sel_i[1] & src_i.cmp2) |
               (sel_i[2] & src_i.trip);
  end

endmodule
`default_nettype wire

// *** verilog/pasr_top.sv ***
// PWM auto-shutdown and auto-restart controller with APB register access
`timescale 1ns/100ps
`default_nettype none
module pasr_top #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  input  wire logic                   ce_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [ADDR_W-1:0]      paddr_i,
  input  wire logic [31:0]            pwdata_i,
  input  wire logic [3:0]             pstrb_i,
  output logic [31:0]                 prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // PWM generator side
  input  wire pasr_pkg::pasr_quad_type pwm_i,
  input  wire logic                   period_start_i,
  // Shutdown sources
  input  wire pasr_pkg::pasr_src_type src_i,
  // Pins to bridge drivers
  output pasr_pkg::pasr_quad_type     pin_out_o,
  output pasr_pkg::pasr_quad_type     pin_oe_o,
  // Status levels
  output logic                        shutdown_o,
  output logic                        period_flag_o
);
  import pasr_pkg::*;

  // Register state
  logic          flag_q;
  logic [2:0]    src_sel_q;
  logic [1:0]    ac_state_q;
  logic [1:0]    bd_state_q;
  logic          restart_en_q;
  logic [6:0]    delay_q;
  logic [1:0]    pol_q;
  logic [3:0]    pin_en_q;
  logic          ptf_q;
  logic          seen_q;
  logic          hold_q;
  // Bus state
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   prdata_q;
  logic          pready_d;
  logic          pslverr_d;
  logic [31:0]   prdata_d;
  // Pin state
  pasr_quad_type pin_out_q;
  pasr_quad_type pin_oe_q;
  pasr_quad_type pin_out_d;
  pasr_quad_type pin_oe_d;
  logic          shutdown_q;
  // Decode
  logic          cond;
  logic          shut_now;
  logic          fire;
  logic          wr_fire;
  logic          hit;
  logic [7:0]    word;
  logic          asc_wr;
  logic          dbc_wr;
  logic          pwc_wr;
  logic          pen_wr;
  logic          pst_wr;
  logic          flag_wr;

  // Selects one register on an aligned byte address, upper bits zero
  function automatic logic reg_sel(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        off);
    reg_sel = (addr == ADDR_W'(off));
  endfunction

  assign fire    = psel_i & penable_i & pready_q;
  assign wr_fire = fire & pwrite_i & ~pslverr_q & pstrb_i[0];
  assign word    = pwdata_i[7:0];
  assign asc_wr  = wr_fire & reg_sel(paddr_i, PASR_ASC_OFF);
  assign dbc_wr  = wr_fire & reg_sel(paddr_i, PASR_DBC_OFF);
  assign pwc_wr  = wr_fire & reg_sel(paddr_i, PASR_PWC_OFF);
  assign pen_wr  = wr_fire & reg_sel(paddr_i, PASR_PEN_OFF);
  assign pst_wr  = wr_fire & reg_sel(paddr_i, PASR_PST_OFF);
  assign flag_wr = asc_wr;
  assign hit     = reg_sel(paddr_i, PASR_ASC_OFF) |
                   reg_sel(paddr_i, PASR_DBC_OFF) |
                   reg_sel(paddr_i, PASR_PWC_OFF) |
                   reg_sel(paddr_i, PASR_PEN_OFF) |
                   reg_sel(paddr_i, PASR_PST_OFF);

  // Source code 000 yields no cause at all
  pasr_src_decode u_src (
    .sel_i    (src_sel_q),
    .src_i    (src_i),
    .active_o (cond)
  );

  // Live cause, sticky flag and period hold all force the safe state
  assign shut_now = cond | flag_q | hold_q;

  // APB answer: one wait state, data and error registered
  always_comb begin
    pready_d  = psel_i & penable_i & ~pready_q;
    pslverr_d = pready_d & ~hit;
    prdata_d  = 32'h0;
    if (pready_d & ~pwrite_i) begin
      if (reg_sel(paddr_i, PASR_ASC_OFF)) begin
        prdata_d[7:0] = {flag_q, src_sel_q, ac_state_q, bd_state_q};
      end else if (reg_sel(paddr_i, PASR_DBC_OFF)) begin
        prdata_d[7:0] = {restart_en_q, delay_q};
      end else if (reg_sel(paddr_i, PASR_PWC_OFF)) begin
        prdata_d[1:0] = pol_q;
      end else if (reg_sel(paddr_i, PASR_PEN_OFF)) begin
        prdata_d[PASR_PEN_HI:0] = pin_en_q;
      end else if (reg_sel(paddr_i, PASR_PST_OFF)) begin
        prdata_d[PASR_PTF_BIT] = ptf_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (ce_i) begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Configuration fields of the shutdown control register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      src_sel_q  <= PASR_ASC_RST[PASR_SRC_HI:PASR_SRC_LO];
      ac_state_q <= PASR_ASC_RST[PASR_AC_HI:PASR_AC_LO];
      bd_state_q <= PASR_ASC_RST[PASR_BD_HI:PASR_BD_LO];
    end else if (ce_i && asc_wr) begin
      src_sel_q  <= word[PASR_SRC_HI:PASR_SRC_LO];
      ac_state_q <= word[PASR_AC_HI:PASR_AC_LO];
      bd_state_q <= word[PASR_BD_HI:PASR_BD_LO];
    end
  end

  // Delay count is kept for software only; dead band lives elsewhere
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      restart_en_q <= PASR_DBC_RST[PASR_RST_EN_BIT];
      delay_q      <= PASR_DBC_RST[PASR_DLY_HI:PASR_DLY_LO];
    end else if (ce_i && dbc_wr) begin
      restart_en_q <= word[PASR_RST_EN_BIT];
      delay_q      <= word[PASR_DLY_HI:PASR_DLY_LO];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pol_q <= PASR_POL_RST;
    end else if (ce_i && pwc_wr) begin
      pol_q <= word[1:0];
    end
  end

  // Pins stay undriven until software enables them
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_en_q <= PASR_PEN_RST;
    end else if (ce_i && pen_wr) begin
      pin_en_q <= word[PASR_PEN_HI:0];
    end
  end

  // Shutdown flag: a live cause wins over any write, so a clear is lost
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      if (cond) begin
        flag_q <= 1'b1;
      end else if (flag_wr) begin
        flag_q <= word[PASR_FLAG_BIT];
      end else if (restart_en_q) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Hold safe state until a period begins with the flag clear
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      hold_q <= 1'b0;
    end else if (ce_i) begin
      if (cond || flag_q) begin
        hold_q <= 1'b1;
      end else if (period_start_i) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Period timer flag; a new set wins over a write-one clear
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      seen_q <= 1'b0;
      ptf_q  <= 1'b0;
    end else if (ce_i) begin
      if (period_start_i) begin
        seen_q <= 1'b1;
      end
      if (period_start_i && seen_q) begin
        ptf_q <= 1'b1;
      end else if (pst_wr && word[PASR_PTF_BIT]) begin
        ptf_q <= 1'b0;
      end
    end
  end

  // Both pairs share one stage design
  pasr_pair_stage u_ac (
    .pwm_i     ({pwm_i.c, pwm_i.a}),
    .en_i      ({pin_en_q[2], pin_en_q[0]}),
    .pol_low_i (pol_q[PASR_POL_AC_BIT]),
    .state_i   (pasr_pss_type'(ac_state_q)),
    .shut_i    (shut_now),
    .out_o     ({pin_out_d.c, pin_out_d.a}),
    .oe_o      ({pin_oe_d.c, pin_oe_d.a})
  );

  pasr_pair_stage u_bd (
    .pwm_i     ({pwm_i.d, pwm_i.b}),
    .en_i      ({pin_en_q[3], pin_en_q[1]}),
    .pol_low_i (pol_q[PASR_POL_BD_BIT]),
    .state_i   (pasr_pss_type'(bd_state_q)),
    .shut_i    (shut_now),
    .out_o     ({pin_out_d.d, pin_out_d.b}),
    .oe_o      ({pin_oe_d.d, pin_oe_d.b})
  );

  // Registered pins cost one cycle of shutdown latency
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_out_q  <= '0;
      pin_oe_q   <= '0;
      shutdown_q <= 1'b0;
    end else if (ce_i) begin
      pin_out_q  <= pin_out_d;
      pin_oe_q   <= pin_oe_d;
      shutdown_q <= shut_now;
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign pin_out_o     = pin_out_q;
  assign pin_oe_o      = pin_oe_q;
  assign shutdown_o    = shutdown_q;
  assign period_flag_o = ptf_q;

  // Checks

  a_flag_on_cause: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && cond) |=> flag_q ##0 shutdown_q)
    else $error("flag or shutdown missing after cause");

  a_trip_select: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (src_sel_q == PASR_SRC_TRIP) |-> (cond == src_i.trip))
    else $error("trip-only select does not follow trip pin");

  a_bd_tristate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && shut_now && bd_state_q[1]) |=> (!pin_oe_q.b && !pin_oe_q.d))
    else $error("B/D pins driven during tri-state shutdown");

  a_auto_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && restart_en_q && flag_q && !cond && !flag_wr) |=> !flag_q)
    else $error("flag not cleared by auto restart");

  a_manual_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && !restart_en_q && flag_q && !flag_wr) |=> flag_q)
    else $error("flag dropped without firmware clear");

  a_resume_period: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $fell(hold_q) |-> ($past(period_start_i) && !$past(flag_q)))
    else $error("outputs resumed off a period start");

  a_write_ignored: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && cond && flag_wr && !word[PASR_FLAG_BIT]) |=> flag_q)
    else $error("flag cleared while cause active");

  a_sw_force: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && flag_wr && word[PASR_FLAG_BIT]) |=> flag_q ##1 shutdown_q)
    else $error("software force did not shut down");

  a_polarity: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && !shut_now) |=>
      (pin_out_q.a == ($past(pwm_i.a) ^ $past(pol_q[PASR_POL_AC_BIT]))))
    else $error("A output polarity wrong");

  a_period_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && period_start_i && seen_q) |=> ptf_q)
    else $error("period flag not set on second period");

  a_no_drive_unen: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pin_oe_q != 4'h0) |-> ($past(pin_en_q) != 4'h0))
    else $error("pin driven while not enabled");

  a_ac_high: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && shut_now && ac_state_q == PASR_PSS_HIGH) |=>
      (pin_out_q.a && pin_out_q.c))
    else $error("A/C not driven high in shutdown");

  a_none_select: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (src_sel_q == PASR_SRC_NONE) |-> !cond)
    else $error("disabled sources still raise a cause");

  a_period_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (ce_i && period_start_i && flag_q) |=> (hold_q && shut_now))
    else $error("outputs left shutdown at a flagged period start");

endmodule
`default_nettype wire
